// [tb/sdc_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module sdc_chk (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic SERIAL_LOAD_I,
  input wire logic PAR_LOAD_N_I,
  input wire logic [sdc_pkg::LOOP_W-1:0] PAR_LOOP_I,
  input wire logic [sdc_pkg::OUT_CODE_W-1:0] PAR_OUT_CODE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_RD_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic SYNTH_OUT_O,
  input wire logic SYNTH_OUT_N_O,
  input wire logic OBSERVE_O
);
  import sdc_pkg::*;
  // ----
  // Port checks
  // ----
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  // Status read, plain, after a held parallel strobe, or with latches quiet
  sequence st_rd;
    REG_RD_I && REG_ADDR_I == 8'h04;
  endsequence
  sequence par_rd;
    (!PAR_LOAD_N_I && $stable(PAR_LOOP_I) && $stable(PAR_OUT_CODE_I)) [*6] ##0 st_rd;
  endsequence
  sequence quiet_rd(logic [2:0] c);
    (PAR_LOAD_N_I && !SERIAL_LOAD_I) [*4] ##0 st_rd ##1 REG_RDATA_O[13:11] == c;
  endsequence
  AST_PAIR: assert property (SYNTH_OUT_N_O != SYNTH_OUT_O)
    else $error("output pair not complementary");
  AST_RD_IDLE: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
    else $error("read data outside read slot");
  AST_UNMAPPED: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) > 8'h08 |-> REG_RDATA_O == 0)
    else $error("unmapped read not zero");
  AST_PAR_CLR: assert property (par_rd |=> REG_RDATA_O[13:11] == 3'h0)
    else $error("observe code not cleared");
  AST_PAR_FOLLOW: assert property (par_rd |=> REG_RDATA_O[10:0] == $past({PAR_OUT_CODE_I, PAR_LOOP_I}))
    else $error("latches not following parallel pins");
  AST_BYPASS: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) == 8'h04 |->
    REG_RDATA_O[14] == (REG_RDATA_O[13] && !REG_RDATA_O[11])) else $error("bypass flag wrong");
  AST_OBS_HIGH: assert property (quiet_rd(3'h1) |-> ##1 OBSERVE_O [*2])
    else $error("observe not high");
  AST_OBS_LOW: assert property (quiet_rd(3'h5) |-> ##1 !OBSERVE_O [*2])
    else $error("observe not low");
endmodule // sdc_chk
`default_nettype wire

// [tb/sdc_loader.sv]
`timescale 1ns/1ps
`default_nettype none
// Board controller driving the configuration pins, each level held 4 clocks
module sdc_loader (
  input wire logic clk_i,
  output logic sclk_o,
  output logic sdata_o,
  output logic sload_o,
  output logic pload_n_o,
  output logic [8:0] ploop_o,
  output logic [1:0] pcode_o
);
  // Idle levels, parallel pins at their pull-up level
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    sload_o = 1'b0;
    pload_n_o = 1'b1;
    ploop_o = 9'h1ff;
    pcode_o = 2'h3;
  end
  // Slow pacing keeps the shift clock far below its ceiling
  task automatic hold();
    repeat (4) @(posedge clk_i);
  endtask
  task automatic commit();
    sload_o <= 1'b1;
    hold();
    sload_o <= 1'b0;
    hold();
  endtask
  // Fourteen bits, most significant first, then a commit pulse
  task automatic send(input logic [13:0] w);
    for (int i = 13; i >= 0; i--) begin
      sdata_o <= w[i];
      hold();
      sclk_o <= 1'b1;
      hold();
      sclk_o <= 1'b0;
    end
    sdata_o <= ~w[0];
    hold();
    commit();
  endtask
  task automatic pins(input logic [8:0] m, input logic [1:0] n);
    ploop_o <= m;
    pcode_o <= n;
    hold();
  endtask
  // Power-on parallel load, released later by par_high
  task automatic par_low(input logic [8:0] m, input logic [1:0] n);
    pload_n_o <= 1'b0;
    pins(m, n);
    hold();
  endtask
  task automatic par_high();
    pload_n_o <= 1'b1;
    hold();
  endtask
  task automatic clocks(input int n);
    repeat (n) begin
      sclk_o <= 1'b1;
      hold();
      sclk_o <= 1'b0;
      hold();
    end
  endtask
endmodule // sdc_loader
`default_nettype wire

// [tb/sdc_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("Error %0t %h %h", $time, a, b); end end
module sdc_tb_top;
  import sdc_pkg::*;
  typedef struct {logic [13:0] w; int sp; int op; logic lv;} sdc_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic sel = 1'b0;
  int bad_count = 0;
  int checks = 0;
  int p;
  wire logic [31:0] rdata;
  wire logic synth, synth_n, obs, sclk, sdata, sload, pload_n;
  wire logic [8:0] ploop;
  wire logic [1:0] pcode;
  wire logic cmp, fb;
  logic aux = 1'b0;
  wire logic msig = aux ? (sel ? fb : cmp) : (sel ? obs : synth);
  // Loads: word, synth period, observe period (0 = level lv)
  sdc_row_t rows [6] = '{'{14'h08c8, 16, 0, 1'b1}, '{14'h2ac9, 32, 0, 1'b0},
    '{14'h04c9, 64, 0, 1'b0}, '{14'h16ca, 128, 128, 1'b0}, '{14'h18cb, 16, 1624, 1'b0},
    '{14'h38ca, 16, 64, 1'b0}};
  // Clock, oscillator at 1/8 and crystal at 1/16 of it
  always #4 clk = ~clk;
  always @(posedge clk) cnt <= cnt + 4'h1;
  sdc_top i_sdc_top (.CLOCK_I(clk), .RST_N_I(rst_n), .CRYSTAL_CLK_I(cnt[3]), .OSC_CLK_I(cnt[2]),
    .SHIFT_CLK_I(sclk), .SHIFT_DATA_I(sdata), .SERIAL_LOAD_I(sload), .PAR_LOAD_N_I(pload_n),
    .PAR_LOOP_I(ploop), .PAR_OUT_CODE_I(pcode), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata), .SYNTH_OUT_O(synth),
    .SYNTH_OUT_N_O(synth_n), .OBSERVE_O(obs), .PLL_COMPARE_CLOCK_O(cmp), .LOOP_FEEDBACK_O(fb));
  sdc_loader i_sdc_loader (.clk_i(clk), .sclk_o(sclk), .sdata_o(sdata), .sload_o(sload),
    .pload_n_o(pload_n), .ploop_o(ploop), .pcode_o(pcode));
  // ----
  // Bus cycles and measurement
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  // Clocks between two rising edges of the selected output
  task automatic per(input logic s, output int n);
    logic q;
    sel = s;
    n = -1;
    for (int k = 0; k < 4000; k++) begin
      q = msig;
      @(posedge clk);
      #1;
      if (n >= 0) n++;
      if (!q && msig === 1'b1) begin
        if (n > 0) break;
        n = 0;
      end
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #700000;
    bad_count++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    `CHK(synth_n, 1'b1)
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(8'h00, 32'h1);
    rdc(8'h04, 32'h0);
    rdc(8'h0c, 32'h0);
    $display("reset done");
    foreach (rows[i]) begin
      i_sdc_loader.send(rows[i].w);
      rdc(8'h08, {18'h0, rows[i].w});
      rdc(8'h04, {18'h0, rows[i].w});
      per(1'b0, p);
      per(1'b0, p);
      `CHK(p, rows[i].sp)
      if (rows[i].op == 0) begin
        `CHK(obs, rows[i].lv)
      end else begin
        per(1'b1, p);
        per(1'b1, p);
        `CHK(p, rows[i].op)
      end
      $display("row %0d done", i);
    end
    // Compare clock and loop feedback with the last row's loop value of 202
    aux = 1'b1;
    per(1'b0, p);
    per(1'b0, p);
    `CHK(p, 128)
    per(1'b1, p);
    per(1'b1, p);
    `CHK(p, 1616)
    aux = 1'b0;
    $display("feedback done");
    i_sdc_loader.par_low(9'h12c, 2'h1);
    rdc(8'h04, 32'h032c);
    i_sdc_loader.send(14'h38ca);
    rdc(8'h04, 32'h032c);
    `CHK(obs, 1'b1)
    i_sdc_loader.par_high();
    i_sdc_loader.pins(9'h0c8, 2'h3);
    rdc(8'h04, 32'h032c);
    i_sdc_loader.commit();
    rdc(8'h04, 32'h38ca);
    $display("parallel done");
    i_sdc_loader.send(14'h20c8);
    rdc(8'h04, 32'h60c8);
    fork
      i_sdc_loader.clocks(1000);
      begin
        per(1'b0, p);
        per(1'b0, p);
        `CHK(p, 16)
        per(1'b1, p);
        per(1'b1, p);
        `CHK(p, 1600)
      end
    join
    $display("bypass done");
    wr(8'h04, 32'h0);
    rdc(8'h04, 32'h60c8);
    wr(8'h00, 32'h0);
    rdc(8'h00, 32'h0);
    fork
      i_sdc_loader.clocks(20);
      per(1'b0, p);
    join
    `CHK(p, -1)
    `CHK(synth, 1'b0)
    $display("register done");
    conclude();
  end
endmodule // sdc_tb_top
bind sdc_top sdc_chk i_sdc_chk (.CLOCK_I, .RST_N_I, .SERIAL_LOAD_I, .PAR_LOAD_N_I, .PAR_LOOP_I,
  .PAR_OUT_CODE_I, .REG_ADDR_I, .REG_RD_I, .REG_RDATA_O, .SYNTH_OUT_O, .SYNTH_OUT_N_O, .OBSERVE_O);
`default_nettype wire

// [verilog/sdc_divider.sv]
`timescale 1ns/1ps
`default_nettype none
// Counts input events and forms a divided square wave; odd ratios skew duty
module sdc_divider #(
  parameter int W = 9
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic [W-1:0] ratio_i,
  output logic div_o
);
  logic [W-1:0] count;
  wire wrap = (count >= ratio_i - W'(1));
  wire [W-1:0] next_count = wrap ? '0 : count + W'(1);
  wire next_div = (next_count < (ratio_i >> 1));
  wire usable = (ratio_i >= W'(2));

  // Advance only on an event, and only with a ratio of two or more
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
      div_o <= 1'b0;
    end else if (tick_i && usable) begin
      count <= next_count;
      div_o <= next_div;
    end
  end
endmodule // sdc_divider
`default_nettype wire

// [verilog/sdc_pkg.sv]
// Overview of operation
// - Output is crystal/8 times M over N
// - Observe codes 0xx show chain, high, reference, loop
// - Observe code loads only from serial chain
// - Parallel strobe low clears observe code
// - Stream order: observe, output code, loop value
// - Each field shifted most significant bit first
// - Observe code 100 selects bypass mode
// - Bypass feeds shift clock into both dividers
// - Bypass loop counter duty need not be half
// - Fourteen bit chain shifts on shift clock rise
// - Serial strobe high makes latches follow chain
// - Parallel strobe low overrides, rising edge captures
// - Output code selects divide by 2,4,8,16
`default_nettype none
package sdc_pkg;
  // ----------------------------------------------------------------
  // Field sizes and chain layout
  // ----------------------------------------------------------------
  localparam int CHAIN_LEN = 14;
  localparam int OBS_W = 3;
  localparam int OUT_CODE_W = 2;
  localparam int LOOP_W = 9;
  localparam int OBS_POS = 11;
  localparam int OUT_CODE_POS = 9;
  localparam int LOOP_POS = 0;
  localparam int DIV_W = 9;
  // ----------------------------------------------------------------
  // Divider constants
  // ----------------------------------------------------------------
  localparam logic [8:0] REF_RATIO = 9'h008;
  localparam logic [8:0] OUT4_RATIO = 9'h004;
  localparam logic [8:0] OUT_BASE_RATIO = 9'h002;
  // ----------------------------------------------------------------
  // Observe codes
  // ----------------------------------------------------------------
  localparam logic [2:0] OBS_CHAIN = 3'h0;
  localparam logic [2:0] OBS_HIGH = 3'h1;
  localparam logic [2:0] OBS_REF = 3'h2;
  localparam logic [2:0] OBS_LOOP = 3'h3;
  localparam logic [2:0] OBS_BYPASS = 3'h4;
  localparam logic [2:0] OBS_LOW = 3'h5;
  localparam logic [2:0] OBS_BYP_LOOP = 3'h6;
  localparam logic [2:0] OBS_OUT4 = 3'h7;
  // ----------------------------------------------------------------
  // Register port map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CHAIN_OFS = 8'h08;
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [13:0] CHAIN_RESET = 14'h0000;
  localparam logic [8:0] LOOP_RESET = 9'h000;
  localparam logic [1:0] OUT_CODE_RESET = 2'h0;
  localparam logic [2:0] OBS_RESET = 3'h0;
endpackage
`default_nettype wire

// [verilog/sdc_top.sv]
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sdc_top (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic CRYSTAL_CLK_I,
  input wire logic OSC_CLK_I,
  input wire logic SHIFT_CLK_I,
  input wire logic SHIFT_DATA_I,
  input wire logic SERIAL_LOAD_I,
  input wire logic PAR_LOAD_N_I,
  input wire logic [sdc_pkg::LOOP_W-1:0] PAR_LOOP_I,
  input wire logic [sdc_pkg::OUT_CODE_W-1:0] PAR_OUT_CODE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  output logic SYNTH_OUT_O,
  output logic SYNTH_OUT_N_O,
  output logic OBSERVE_O,
  output logic PLL_COMPARE_CLOCK_O,
  output logic LOOP_FEEDBACK_O
);
  import sdc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [LOOP_W-1:0] ploop1;
  logic [LOOP_W-1:0] ploop2;
  logic [OUT_CODE_W-1:0] pcode1;
  logic [OUT_CODE_W-1:0] pcode2;
  wire [NSYNC-1:0] pins = {PAR_LOAD_N_I, SERIAL_LOAD_I, SHIFT_DATA_I,
                           SHIFT_CLK_I, OSC_CLK_I, CRYSTAL_CLK_I};

  // Two flops per pin, a third only for edge detection
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      ploop1 <= '0;
      ploop2 <= '0;
      pcode1 <= '0;
      pcode2 <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      ploop1 <= PAR_LOOP_I;
      ploop2 <= ploop1;
      pcode1 <= PAR_OUT_CODE_I;
      pcode2 <= pcode1;
    end
  end

  wire xtal_rise = sync2[0] & ~sync3[0];
  wire osc_rise = sync2[1] & ~sync3[1];
  wire sclk_rise = sync2[2] & ~sync3[2];
  wire sdata = sync2[3];
  wire sload = sync2[4];
  wire pload_n = sync2[5];

  // ----------------------------------------------------------------
  // Serial chain and configuration latches
  // ----------------------------------------------------------------
  logic [CHAIN_LEN-1:0] chain;
  logic [LOOP_W-1:0] loop_val;
  logic [OUT_CODE_W-1:0] out_code;
  logic [OBS_W-1:0] obs_code;
  logic out_enable;

  // Shift on each shift clock rise; first bit ends at the top
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      chain <= CHAIN_RESET;
    end else if (sclk_rise) begin
      chain <= {chain[CHAIN_LEN-2:0], sdata};
    end
  end

  // Fields of the chain: observe first, then output code, then loop value
  wire [OBS_W-1:0] chain_obs = chain[OBS_POS +: OBS_W];
  wire [OUT_CODE_W-1:0] chain_code = chain[OUT_CODE_POS +: OUT_CODE_W];
  wire [LOOP_W-1:0] chain_loop = chain[LOOP_POS +: LOOP_W];

  // Parallel strobe low wins; serial strobe high follows the chain
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      loop_val <= LOOP_RESET;
      out_code <= OUT_CODE_RESET;
      obs_code <= OBS_RESET;
    end else if (!pload_n) begin
      loop_val <= ploop2;
      out_code <= pcode2;
      obs_code <= OBS_RESET;
    end else if (sload) begin
      loop_val <= chain_loop;
      out_code <= chain_code;
      obs_code <= chain_obs;
    end
  end

  // ----------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------
  wire bypass = (obs_code == OBS_BYPASS) || (obs_code == OBS_BYP_LOOP);
  wire div_tick = bypass ? sclk_rise : osc_rise;
  wire [DIV_W-1:0] out_ratio = OUT_BASE_RATIO << out_code;
  wire ref_div;
  wire loop_div;
  wire out_div;
  wire out4_div;
  logic out_prev;
  wire out_rise = out_div & ~out_prev;

  // Crystal over eight forms the compare clock
  sdc_divider #(.W(DIV_W)) u_ref (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .tick_i(xtal_rise),
    .ratio_i(REF_RATIO),
    .div_o(ref_div)
  );

  // Loop counter; duty is skewed for odd loop values
  sdc_divider #(.W(DIV_W)) u_loop (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .tick_i(div_tick),
    .ratio_i(loop_val),
    .div_o(loop_div)
  );

  // Output divider by 2, 4, 8 or 16
  sdc_divider #(.W(DIV_W)) u_out (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .tick_i(div_tick),
    .ratio_i(out_ratio),
    .div_o(out_div)
  );

  // Output over four for the observe pin
  sdc_divider #(.W(DIV_W)) u_out4 (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .tick_i(out_rise),
    .ratio_i(OUT4_RATIO),
    .div_o(out4_div)
  );

  // ----------------------------------------------------------------
  // Observe selection
  // ----------------------------------------------------------------
  logic next_observe;

  // Pick the node shown on the observe pin
  always_comb begin
    case (obs_code)
      OBS_CHAIN: next_observe = chain[CHAIN_LEN-1];
      OBS_HIGH: next_observe = 1'b1;
      OBS_REF: next_observe = ref_div;
      OBS_LOOP: next_observe = loop_div;
      OBS_BYPASS: next_observe = loop_div;
      OBS_LOW: next_observe = 1'b0;
      OBS_BYP_LOOP: next_observe = loop_div;
      default: next_observe = out4_div;
    endcase
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  wire sel_ctrl = (REG_ADDR_I == CTRL_OFS);
  wire sel_status = (REG_ADDR_I == STATUS_OFS);
  wire sel_chain = (REG_ADDR_I == CHAIN_OFS);
  wire [31:0] status_word = {17'h00000, bypass, obs_code, out_code, loop_val};
  wire [31:0] read_mux = sel_ctrl ? {31'h00000000, out_enable} :
                         sel_status ? status_word :
                         sel_chain ? {18'h00000, chain} : 32'h00000000;
  wire [31:0] next_rdata = REG_RD_I ? read_mux : 32'h00000000;

  // Control write and one-cycle read answer
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      out_enable <= CTRL_RESET;
      REG_RDATA_O <= '0;
    end else begin
      if (REG_WR_I && sel_ctrl) begin
        out_enable <= REG_WDATA_I[0];
      end
      REG_RDATA_O <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      out_prev <= 1'b0;
      SYNTH_OUT_O <= 1'b0;
      SYNTH_OUT_N_O <= 1'b1;
      OBSERVE_O <= 1'b0;
      PLL_COMPARE_CLOCK_O <= 1'b0;
      LOOP_FEEDBACK_O <= 1'b0;
    end else begin
      out_prev <= out_div;
      SYNTH_OUT_O <= out_enable & out_div;
      SYNTH_OUT_N_O <= ~(out_enable & out_div);
      OBSERVE_O <= next_observe;
      PLL_COMPARE_CLOCK_O <= ref_div;
      LOOP_FEEDBACK_O <= loop_div;
    end
  end
endmodule // sdc_top
`default_nettype wire
